// *** hdl/erl_pkg.sv ***
package erl_pkg;
    // *********************************************************************
    // Sizes
    // *********************************************************************
    localparam int NVM_AW        = 13;
    localparam int REG_AW        = 7;
    localparam int PAGE_BYTES    = 64;
    localparam int PAGE_OFF_W    = 6;
    localparam int PAGE_NUM_W    = NVM_AW - PAGE_OFF_W;

    // *********************************************************************
    // Non-volatile image layout
    // *********************************************************************
    localparam logic [12:0] NVM_SAM_ADDR    = 13'h0022;
    localparam logic [12:0] NVM_DEF_RX      = 13'h0023;
    localparam logic [12:0] NVM_DEF_TX      = 13'h0024;
    localparam logic [12:0] NVM_IMG_BASE    = 13'h0040;
    localparam logic [12:0] NVM_RSP_TX_BASE = 13'h1c00;
    localparam logic [12:0] NVM_RSP_RX_BASE = 13'h1e00;
    localparam logic [7:0]  IMG_LEN         = 8'h80;
    localparam logic [7:0]  TX_LEN          = 8'h10;
    localparam logic [7:0]  RX_LEN          = 8'h08;
    localparam logic [6:0]  TX_REG_BASE     = 7'h28;
    localparam logic [6:0]  RX_REG_BASE     = 7'h38;
    localparam logic [6:0]  TX_CRC_SEED_REG = 7'h2c;

    // *********************************************************************
    // Bus register map, control bits and response codes
    // *********************************************************************
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_PROT_SEL = 8'h04;
    localparam logic [7:0]  OFS_STATUS   = 8'h08;
    localparam logic [7:0]  OFS_IMG_BASE = 8'h0c;
    localparam logic [7:0]  OFS_NVM_PAGE = 8'h10;
    localparam logic [7:0]  OFS_NVM_WR   = 8'h14;
    localparam int          CTRL_LOAD_BIT = 0;
    localparam int          CTRL_DONE_CLR = 1;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;

    typedef enum logic [1:0] {
        ERL_IDLE = 2'b00,
        ERL_RD   = 2'b01,
        ERL_WR   = 2'b11
    } erl_state_t;

    typedef enum logic [1:0] {
        PH_CFG = 2'b00,
        PH_IMG = 2'b01,
        PH_TX  = 2'b11,
        PH_RX  = 2'b10
    } erl_phase_t;

    typedef struct packed {
        logic              en;
        logic [REG_AW-1:0] addr;
        logic [7:0]        data;
    } erl_reg_wr_t;

    typedef struct packed {
        logic              en;
        logic [NVM_AW-1:0] addr;
        logic [7:0]        data;
    } erl_nvm_wr_t;
endpackage

// *** hdl/erl_loader.sv ***
`timescale 1ns/1ps
// Function
// - Secure-module bus address always from stored image.
// - Protocol entry: 16 transmit, 8 receive bytes.
// - After startup copy image bytes into registers.
// - Write only read/write or dynamic bits.
// - Copy addresses follow protocol, user changeable.
// - Protocol-load command copies chosen protocol settings.
// - Image starts at 40 hex, register order.
// - Transmit CRC seed enables automatic CRC append.
// - Non-volatile writes confined to one page.
// - Protocol-load reads read-only protocol settings area (here pages 70-7f hex stay writable through the page write).
module erl_loader
    import erl_pkg::*;
#(
    parameter logic [12:0] IMG_BASE_RST = NVM_IMG_BASE
) (
    input  wire logic              CLK_IN,
    input  wire logic              RESET_N_IN,
    input  wire logic [7:0]        S_AXI_AWADDR_IN,
    input  wire logic              S_AXI_AWVALID_IN,
    output logic                   S_AXI_AWREADY_OUT,
    input  wire logic [31:0]       S_AXI_WDATA_IN,
    input  wire logic [3:0]        S_AXI_WSTRB_IN,
    input  wire logic              S_AXI_WVALID_IN,
    output logic                   S_AXI_WREADY_OUT,
    output logic [1:0]             S_AXI_BRESP_OUT,
    output logic                   S_AXI_BVALID_OUT,
    input  wire logic              S_AXI_BREADY_IN,
    input  wire logic [7:0]        S_AXI_ARADDR_IN,
    input  wire logic              S_AXI_ARVALID_IN,
    output logic                   S_AXI_ARREADY_OUT,
    output logic [31:0]            S_AXI_RDATA_OUT,
    output logic [1:0]             S_AXI_RRESP_OUT,
    output logic                   S_AXI_RVALID_OUT,
    input  wire logic              S_AXI_RREADY_IN,
    output logic                   NVM_RD_EN_OUT,
    output logic [NVM_AW-1:0]      NVM_RD_ADDR_OUT,
    input  wire logic [7:0]        NVM_RD_DATA_IN,
    output erl_nvm_wr_t            NVM_WR_OUT,
    output erl_reg_wr_t            REG_WR_OUT,
    input  wire logic [7:0]        REG_OLD_DATA_IN,
    input  wire logic [7:0]        REG_RW_MASK_IN,
    output logic                   HOST_REG_GRANT_OUT,
    output logic                   BUSY_OUT,
    output logic [7:0]             SAM_BUS_ADDR_OUT,
    output logic [7:0]             TX_CRC_SEED_OUT,
    output logic                   TX_CRC_EN_OUT
);
    // *********************************************************************
    // Bus slave state
    // *********************************************************************
    logic              aw_got_ff, nxt_aw_got;
    logic              w_got_ff, nxt_w_got;
    logic [7:0]        awaddr_ff, nxt_awaddr;
    logic [31:0]       wdata_ff, nxt_wdata;
    logic [3:0]        wstrb_ff, nxt_wstrb;
    logic              bvalid_ff, nxt_bvalid;
    logic [1:0]        bresp_ff, nxt_bresp;
    logic              rvalid_ff, nxt_rvalid;
    logic [1:0]        rresp_ff, nxt_rresp;
    logic [31:0]       rdata_ff, nxt_rdata;
    logic [7:0]        sel_rx_ff, nxt_sel_rx;
    logic [7:0]        sel_tx_ff, nxt_sel_tx;
    logic [12:0]       img_base_ff, nxt_img_base;
    logic [6:0]        page_ff, nxt_page;
    erl_nvm_wr_t       nvm_wr_ff, nxt_nvm_wr;
    logic              load_req_ff, nxt_load_req;
    logic              done_ff, nxt_done;

    // *********************************************************************
    // Loader state
    // *********************************************************************
    erl_state_t        state_ff, nxt_state;
    erl_phase_t        phase_ff, nxt_phase;
    logic [12:0]       src_ff, nxt_src;
    logic [6:0]        dst_ff, nxt_dst;
    logic [7:0]        left_ff, nxt_left;
    logic [7:0]        sam_ff, nxt_sam;
    logic [7:0]        seed_ff, nxt_seed;
    erl_reg_wr_t       reg_wr_ff, nxt_reg_wr;
    logic              copy_done;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  stb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (stb[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign S_AXI_AWREADY_OUT  = !aw_got_ff && !bvalid_ff;
    assign S_AXI_WREADY_OUT   = !w_got_ff && !bvalid_ff;
    assign S_AXI_BVALID_OUT   = bvalid_ff;
    assign S_AXI_BRESP_OUT    = bresp_ff;
    assign S_AXI_ARREADY_OUT  = !rvalid_ff;
    assign S_AXI_RVALID_OUT   = rvalid_ff;
    assign S_AXI_RDATA_OUT    = rdata_ff;
    assign S_AXI_RRESP_OUT    = rresp_ff;
    assign NVM_WR_OUT         = nvm_wr_ff;
    assign REG_WR_OUT         = reg_wr_ff;
    // Busy also covers the last register write, which lands after idle.
    assign BUSY_OUT           = (state_ff != ERL_IDLE) || reg_wr_ff.en;
    assign HOST_REG_GRANT_OUT = !BUSY_OUT;
    assign SAM_BUS_ADDR_OUT   = sam_ff;
    assign TX_CRC_SEED_OUT    = seed_ff;
    assign TX_CRC_EN_OUT      = (seed_ff != 8'h00);
    assign NVM_RD_EN_OUT      = (state_ff == ERL_RD);
    assign NVM_RD_ADDR_OUT    = src_ff;

    // *********************************************************************
    // Register bus
    // *********************************************************************
    always_comb begin
        logic [31:0] wv;
        wv           = 32'h0000_0000;
        nxt_aw_got   = aw_got_ff;
        nxt_w_got    = w_got_ff;
        nxt_awaddr   = awaddr_ff;
        nxt_wdata    = wdata_ff;
        nxt_wstrb    = wstrb_ff;
        nxt_bvalid   = bvalid_ff;
        nxt_bresp    = bresp_ff;
        nxt_rvalid   = rvalid_ff;
        nxt_rresp    = rresp_ff;
        nxt_rdata    = rdata_ff;
        nxt_sel_rx   = sel_rx_ff;
        nxt_sel_tx   = sel_tx_ff;
        nxt_img_base = img_base_ff;
        nxt_page     = page_ff;
        nxt_nvm_wr   = '0;
        nxt_load_req = load_req_ff && !(state_ff == ERL_IDLE);
        nxt_done     = done_ff;
        if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = S_AXI_AWADDR_IN;
        end
        if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
            nxt_w_got = 1'b1;
            nxt_wdata = S_AXI_WDATA_IN;
            nxt_wstrb = S_AXI_WSTRB_IN;
        end
        if (aw_got_ff && w_got_ff) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp  = RESP_OKAY;
            case (awaddr_ff & 8'hfc)
                OFS_CTRL: begin
                    wv = merge(32'h0000_0000, wdata_ff, wstrb_ff);
                    if (wv[CTRL_LOAD_BIT]) begin
                        nxt_load_req = 1'b1;
                    end
                    if (wv[CTRL_DONE_CLR]) begin
                        nxt_done = 1'b0;
                    end
                end
                OFS_PROT_SEL: begin
                    wv = merge({16'h0000, sel_tx_ff, sel_rx_ff},
                               wdata_ff, wstrb_ff);
                    nxt_sel_rx = wv[7:0];
                    nxt_sel_tx = wv[15:8];
                end
                OFS_IMG_BASE: begin
                    wv = merge({19'h0, img_base_ff}, wdata_ff, wstrb_ff);
                    nxt_img_base = wv[12:0];
                end
                OFS_NVM_PAGE: begin
                    wv = merge({25'h0, page_ff}, wdata_ff, wstrb_ff);
                    nxt_page = wv[6:0];
                end
                OFS_NVM_WR: begin
                    // Offset is only six bits wide, so a write can never
                    // leave the selected page.
                    nxt_nvm_wr.en   = 1'b1;
                    nxt_nvm_wr.addr = {page_ff, wdata_ff[5:0]};
                    nxt_nvm_wr.data = wdata_ff[15:8];
                end
                OFS_STATUS: begin
                end
                default: begin
                    nxt_bresp = RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_ff && S_AXI_BREADY_IN) begin
            nxt_bvalid = 1'b0;
        end
        if (copy_done) begin
            nxt_done = 1'b1;
        end
        if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            case (S_AXI_ARADDR_IN & 8'hfc)
                OFS_CTRL:     nxt_rdata = 32'h0000_0000;
                OFS_PROT_SEL: nxt_rdata = {16'h0000, sel_tx_ff, sel_rx_ff};
                OFS_STATUS:   nxt_rdata = {8'h00, seed_ff, sam_ff, 6'h00,
                                           done_ff, BUSY_OUT};
                OFS_IMG_BASE: nxt_rdata = {19'h0, img_base_ff};
                OFS_NVM_PAGE: nxt_rdata = {25'h0, page_ff};
                OFS_NVM_WR:   nxt_rdata = 32'h0000_0000;
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && S_AXI_RREADY_IN) begin
            nxt_rvalid = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            aw_got_ff   <= 1'b0;
            w_got_ff    <= 1'b0;
            awaddr_ff   <= 8'h00;
            wdata_ff    <= 32'h0000_0000;
            wstrb_ff    <= 4'h0;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= RESP_OKAY;
            rvalid_ff   <= 1'b0;
            rresp_ff    <= RESP_OKAY;
            rdata_ff    <= 32'h0000_0000;
            sel_rx_ff   <= 8'h00;
            sel_tx_ff   <= 8'h00;
            img_base_ff <= IMG_BASE_RST;
            page_ff     <= 7'h00;
            nvm_wr_ff   <= '0;
            load_req_ff <= 1'b0;
            done_ff     <= 1'b0;
        end else begin
            aw_got_ff   <= nxt_aw_got;
            w_got_ff    <= nxt_w_got;
            awaddr_ff   <= nxt_awaddr;
            wdata_ff    <= nxt_wdata;
            wstrb_ff    <= nxt_wstrb;
            bvalid_ff   <= nxt_bvalid;
            bresp_ff    <= nxt_bresp;
            rvalid_ff   <= nxt_rvalid;
            rresp_ff    <= nxt_rresp;
            rdata_ff    <= nxt_rdata;
            sel_rx_ff   <= nxt_sel_rx;
            sel_tx_ff   <= nxt_sel_tx;
            img_base_ff <= nxt_img_base;
            page_ff     <= nxt_page;
            nvm_wr_ff   <= nxt_nvm_wr;
            load_req_ff <= nxt_load_req;
            done_ff     <= nxt_done;
        end
    end

    // *********************************************************************
    // Copy engine
    // *********************************************************************
    always_comb begin
        nxt_state  = state_ff;
        nxt_phase  = phase_ff;
        nxt_src    = src_ff;
        nxt_dst    = dst_ff;
        nxt_left   = left_ff;
        nxt_sam    = sam_ff;
        nxt_seed   = seed_ff;
        nxt_reg_wr = '0;
        copy_done  = 1'b0;
        case (state_ff)
            ERL_IDLE: begin
                if (load_req_ff) begin
                    nxt_state = ERL_RD;
                    nxt_phase = PH_TX;
                    nxt_src   = NVM_RSP_TX_BASE
                              + {1'b0, sel_tx_ff, 4'h0};
                    nxt_dst   = TX_REG_BASE;
                    nxt_left  = TX_LEN;
                end
            end
            ERL_RD: begin
                // Present the target early so that its old value and mask
                // are valid when the byte is merged in the next cycle.
                nxt_state = ERL_WR;
                nxt_reg_wr.addr = dst_ff;
            end
            ERL_WR: begin
                nxt_state = ERL_RD;
                nxt_src   = src_ff + 13'h0001;
                nxt_dst   = dst_ff + 7'h01;
                nxt_left  = left_ff - 8'h01;
                if (phase_ff == PH_CFG) begin
                    // This phase only fetches the secure-module address.
                    case (src_ff)
                        NVM_SAM_ADDR: nxt_sam = NVM_RD_DATA_IN;
                        default:      ;
                    endcase
                end else begin
                    nxt_reg_wr.en   = 1'b1;
                    nxt_reg_wr.addr = dst_ff;
                    nxt_reg_wr.data = (NVM_RD_DATA_IN & REG_RW_MASK_IN)
                                    | (REG_OLD_DATA_IN
                                       & ~REG_RW_MASK_IN);
                    if (dst_ff == TX_CRC_SEED_REG) begin
                        nxt_seed = nxt_reg_wr.data;
                    end
                end
                if (left_ff == 8'h01) begin
                    case (phase_ff)
                        PH_CFG: begin
                            nxt_phase = PH_IMG;
                            nxt_src   = img_base_ff;
                            nxt_dst   = 7'h00;
                            nxt_left  = IMG_LEN;
                        end
                        PH_TX: begin
                            nxt_phase = PH_RX;
                            nxt_src   = NVM_RSP_RX_BASE
                                      + {2'b00, sel_rx_ff, 3'h0};
                            nxt_dst   = RX_REG_BASE;
                            nxt_left  = RX_LEN;
                        end
                        default: begin
                            nxt_state = ERL_IDLE;
                            copy_done = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                nxt_state = ERL_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            state_ff  <= ERL_RD;
            phase_ff  <= PH_CFG;
            src_ff    <= NVM_SAM_ADDR;
            dst_ff    <= 7'h00;
            left_ff   <= 8'h01;
            sam_ff    <= 8'h00;
            seed_ff   <= 8'h00;
            reg_wr_ff <= '0;
        end else begin
            state_ff  <= nxt_state;
            phase_ff  <= nxt_phase;
            src_ff    <= nxt_src;
            dst_ff    <= nxt_dst;
            left_ff   <= nxt_left;
            sam_ff    <= nxt_sam;
            seed_ff   <= nxt_seed;
            reg_wr_ff <= nxt_reg_wr;
        end
    end
endmodule // erl_loader

// *** dv/erl_loader_asserts.sv ***
`timescale 1ns/1ps
module erl_loader_asserts
    import erl_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        NVM_RD_EN_OUT,
    input  wire erl_nvm_wr_t NVM_WR_OUT,
    input  wire erl_reg_wr_t REG_WR_OUT,
    input  wire logic [7:0]  REG_OLD_DATA_IN,
    input  wire logic [7:0]  REG_RW_MASK_IN,
    input  wire logic        HOST_REG_GRANT_OUT,
    input  wire logic        BUSY_OUT,
    input  wire logic [7:0]  SAM_BUS_ADDR_OUT,
    input  wire logic [7:0]  TX_CRC_SEED_OUT
);
    // ****************************************************************
    // Copy tracking
    // ****************************************************************
    logic [6:0] last_addr_ff;
    logic [6:0] nxt_last_addr;
    logic       seen_ff;
    logic       nxt_seen;
    logic [6:0] page_ff;
    logic [6:0] nxt_page;

    // The jump back to the transmit base is legal when a protocol follows.
    always_comb begin
        nxt_last_addr = REG_WR_OUT.en ? REG_WR_OUT.addr : last_addr_ff;
        nxt_seen      = BUSY_OUT && (seen_ff || REG_WR_OUT.en);
        nxt_page      = NVM_WR_OUT.en ? NVM_WR_OUT.addr[12:6] : page_ff;
    end

    always_ff @(posedge CLK_IN) begin
        last_addr_ff <= nxt_last_addr;
        seen_ff      <= RESET_N_IN && nxt_seen;
        page_ff      <= nxt_page;
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    a_busy_no_grant: assert property (
        BUSY_OUT |-> !HOST_REG_GRANT_OUT) else $error("grant while busy");
    a_idle_grant: assert property (
        $fell(BUSY_OUT) |-> ##[0:2] HOST_REG_GRANT_OUT)
        else $error("no grant after copy");
    a_wr_in_copy: assert property (
        REG_WR_OUT.en |-> BUSY_OUT) else $error("register write while idle");
    a_ro_bits_kept: assert property (
        REG_WR_OUT.en |-> ((REG_WR_OUT.data ^ REG_OLD_DATA_IN)
        & ~REG_RW_MASK_IN) == 8'h00) else $error("read-only bits changed");
    a_addr_step: assert property (
        REG_WR_OUT.en && seen_ff |->
        (REG_WR_OUT.addr == last_addr_ff + 7'h01
        || REG_WR_OUT.addr == TX_REG_BASE)) else $error("address skipped");
    a_rd_in_copy: assert property (
        NVM_RD_EN_OUT |-> BUSY_OUT) else $error("array read while idle");
    a_sam_from_copy: assert property (
        $changed(SAM_BUS_ADDR_OUT) |-> BUSY_OUT || $past(BUSY_OUT))
        else $error("bus address changed outside copy");
    a_seed_follows: assert property (
        REG_WR_OUT.en && REG_WR_OUT.addr == TX_CRC_SEED_REG |=>
        TX_CRC_SEED_OUT == $past(REG_WR_OUT.data))
        else $error("seed output stale");
    a_nvm_one_page: assert property (
        NVM_WR_OUT.en && $past(NVM_WR_OUT.en) |->
        NVM_WR_OUT.addr[12:6] == page_ff) else $error("page crossed");

    c_copy: cover property ($rose(BUSY_OUT));
    c_rx: cover property (REG_WR_OUT.en && REG_WR_OUT.addr == RX_REG_BASE);
    c_seed: cover property (REG_WR_OUT.en
        && REG_WR_OUT.addr == TX_CRC_SEED_REG);
endmodule // erl_loader_asserts

// *** dv/erl_nvm_model.sv ***
`timescale 1ns/1ps
module erl_nvm_model
    import erl_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rd_en_in,
    input  wire logic [NVM_AW-1:0] rd_addr_in,
    output logic [7:0]             rd_data_out,
    input  wire erl_nvm_wr_t       nvm_wr_in,
    input  wire erl_reg_wr_t       reg_wr_in,
    output logic [7:0]             reg_old_out,
    output logic [7:0]             reg_mask_out
);
    logic [7:0] mem [0:8191];
    logic [7:0] regs [0:127];

    // Every fourth register has a read-only upper nibble fixed at 5.
    function automatic logic [7:0] mask_of(input logic [6:0] a);
        return (a[1:0] == 2'b11) ? 8'h0f : 8'hff;
    endfunction

    initial begin
        for (int i = 0; i < 8192; i++) mem[i] = 8'(i * 7 + (i >> 8));
        for (int i = 0; i < 128; i++) regs[i] = 8'h50;
        mem[13'h0022] = 8'h5a;
        mem[13'h0042] = 8'h80;
        mem[13'h0043] = 8'h05;
        rd_data_out = 8'h00;
    end

    // Read data stands one cycle; otherwise the bus toggles, never holds.
    always @(posedge clk_in) begin
        if (rd_en_in)
            rd_data_out <= mem[rd_addr_in];
        else
            rd_data_out <= ~rd_data_out;
        if (nvm_wr_in.en)
            mem[nvm_wr_in.addr] <= nvm_wr_in.data;
        if (reg_wr_in.en)
            regs[reg_wr_in.addr] <= reg_wr_in.data;
    end

    assign reg_old_out  = regs[reg_wr_in.addr];
    assign reg_mask_out = mask_of(reg_wr_in.addr);
endmodule // erl_nvm_model

// *** dv/test_erl_loader.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module test_erl_loader
    import erl_pkg::*;
;
    logic clk_in, reset_n_in, aw_valid, w_valid, b_ready, ar_valid, r_ready;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, rd_en, grant, busy;
    logic [7:0] aw_addr, ar_addr, rd_data, reg_old, reg_mask, sam, seed;
    logic [31:0] w_data, r_data;
    logic [3:0] w_strb;
    logic [1:0] b_resp, r_resp;
    logic [12:0] rd_addr;
    erl_nvm_wr_t nvm_wr;
    erl_reg_wr_t reg_wr;
    logic crc_en;
    int errors, check_count, cycles;

    erl_loader DUT (.CLK_IN(clk_in), .RESET_N_IN(reset_n_in),
        .S_AXI_AWADDR_IN(aw_addr), .S_AXI_AWVALID_IN(aw_valid),
        .S_AXI_AWREADY_OUT(aw_ready), .S_AXI_WDATA_IN(w_data),
        .S_AXI_WSTRB_IN(w_strb), .S_AXI_WVALID_IN(w_valid),
        .S_AXI_WREADY_OUT(w_ready), .S_AXI_BRESP_OUT(b_resp),
        .S_AXI_BVALID_OUT(b_valid), .S_AXI_BREADY_IN(b_ready),
        .S_AXI_ARADDR_IN(ar_addr), .S_AXI_ARVALID_IN(ar_valid),
        .S_AXI_ARREADY_OUT(ar_ready), .S_AXI_RDATA_OUT(r_data),
        .S_AXI_RRESP_OUT(r_resp), .S_AXI_RVALID_OUT(r_valid),
        .S_AXI_RREADY_IN(r_ready), .NVM_RD_EN_OUT(rd_en),
        .NVM_RD_ADDR_OUT(rd_addr), .NVM_RD_DATA_IN(rd_data),
        .NVM_WR_OUT(nvm_wr), .REG_WR_OUT(reg_wr),
        .REG_OLD_DATA_IN(reg_old), .REG_RW_MASK_IN(reg_mask),
        .HOST_REG_GRANT_OUT(grant), .BUSY_OUT(busy),
        .SAM_BUS_ADDR_OUT(sam), .TX_CRC_SEED_OUT(seed),
        .TX_CRC_EN_OUT(crc_en));

    erl_nvm_model u_mem (.clk_in(clk_in), .rd_en_in(rd_en),
        .rd_addr_in(rd_addr), .rd_data_out(rd_data), .nvm_wr_in(nvm_wr),
        .reg_wr_in(reg_wr), .reg_old_out(reg_old), .reg_mask_out(reg_mask));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic report_and_stop();
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // A hung handshake or copy ends the run here.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Bus and copy helpers
    // ****************************************************************
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [1:0] exp_resp);
        logic hit_aw, hit_w, got_b;
        logic [1:0] resp;
        got_b = 1'b0;
        @(posedge clk_in);
        aw_addr <= a;
        aw_valid <= 1'b1;
        w_data <= d;
        w_strb <= 4'hf;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        while (!got_b) begin
            @(negedge clk_in);
            hit_aw = aw_ready;
            hit_w = w_ready;
            got_b = b_valid;
            resp = b_resp;
            @(posedge clk_in);
            if (hit_aw) aw_valid <= 1'b0;
            if (hit_w) w_valid <= 1'b0;
        end
        b_ready <= 1'b0;
        `CHK(resp, exp_resp)
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [1:0] exp_resp,
                            input logic [31:0] exp_data);
        logic hit_ar, got_r;
        logic [1:0] resp;
        logic [31:0] data;
        got_r = 1'b0;
        @(posedge clk_in);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        while (!got_r) begin
            @(negedge clk_in);
            hit_ar = ar_ready;
            got_r = r_valid;
            resp = r_resp;
            data = r_data;
            @(posedge clk_in);
            if (hit_ar) ar_valid <= 1'b0;
        end
        r_ready <= 1'b0;
        `CHK(resp, exp_resp)
        `CHK(data, exp_data)
    endtask

    function automatic logic [7:0] exp_reg(input int r, input logic [7:0] s);
        logic [7:0] m;
        m = u_mem.mask_of(r[6:0]);
        return (s & m) | (8'h50 & ~m);
    endfunction

    task automatic wait_copy();
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        while (busy !== 1'b0) @(negedge clk_in);
        @(negedge clk_in);
        `CHK(grant, 1'b1)
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_image(input logic [7:0] r2);
        wait_copy();
        for (int i = 0; i < 128; i++)
            if (i < 'h28 || i > 'h3f)
                `CHK(u_mem.regs[i], exp_reg(i, u_mem.mem[13'h40 + i]))
        `CHK(u_mem.regs[2], r2)
        `CHK(u_mem.regs[3], 8'h55)
        `CHK(sam, u_mem.mem[13'h22])
    endtask

    task automatic t_bus();
        logic [31:0] st;
        st = {8'h00, exp_reg('h2c, u_mem.mem[13'h6c]), u_mem.mem[13'h22],
              8'h02};
        axi_read(OFS_STATUS, RESP_OKAY, st);
        axi_read(OFS_IMG_BASE, RESP_OKAY, 32'h0000_0040);
        axi_read(8'h3c, RESP_SLVERR, 32'h0000_0000);
        axi_write(8'h3c, 32'h0000_00ff, RESP_SLVERR);
    endtask

    task automatic t_protocol(input int tx, input int rx);
        logic [7:0] keep;
        logic [31:0] st;
        keep = u_mem.regs[8'h40];
        axi_write(OFS_PROT_SEL, 32'(tx * 256 + rx), RESP_OKAY);
        axi_read(OFS_PROT_SEL, RESP_OKAY, 32'(tx * 256 + rx));
        axi_write(OFS_CTRL, 32'h1 << CTRL_LOAD_BIT, RESP_OKAY);
        wait_copy();
        for (int i = 0; i < 16; i++)
            `CHK(u_mem.regs['h28 + i], exp_reg('h28 + i, u_mem.mem[NVM_RSP_TX_BASE + 13'(tx * 16 + i)]))
        for (int i = 0; i < 8; i++)
            `CHK(u_mem.regs['h38 + i], exp_reg('h38 + i, u_mem.mem[NVM_RSP_RX_BASE + 13'(rx * 8 + i)]))
        `CHK(seed, u_mem.regs[8'h2c])
        `CHK(crc_en, 1'b1)
        `CHK(u_mem.regs[8'h40], keep)
        axi_write(OFS_CTRL, 32'h1 << CTRL_DONE_CLR, RESP_OKAY);
        st = {8'h00, u_mem.regs['h2c], u_mem.mem[13'h22], 8'h00};
        axi_read(OFS_STATUS, RESP_OKAY, st);
    endtask

    task automatic t_edit_image();
        axi_write(OFS_NVM_PAGE, 32'h0000_0001, RESP_OKAY);
        axi_write(OFS_NVM_WR, 32'h0000_8102, RESP_OKAY);
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_image(8'h81);
    endtask

    initial begin
        {aw_valid, w_valid, b_ready, ar_valid, r_ready} = 5'h00;
        {aw_addr, ar_addr, w_data, w_strb} = 52'h0;
        reset_n_in = 1'b0;
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_image(8'h80);
        t_bus();
        t_protocol(0, 0);
        t_protocol(31, 63);
        t_edit_image();
        report_and_stop();
    end
endmodule // test_erl_loader

bind erl_loader erl_loader_asserts u_chk (.CLK_IN(CLK_IN),
    .RESET_N_IN(RESET_N_IN), .NVM_RD_EN_OUT(NVM_RD_EN_OUT),
    .NVM_WR_OUT(NVM_WR_OUT), .REG_WR_OUT(REG_WR_OUT),
    .REG_OLD_DATA_IN(REG_OLD_DATA_IN), .REG_RW_MASK_IN(REG_RW_MASK_IN),
    .HOST_REG_GRANT_OUT(HOST_REG_GRANT_OUT), .BUSY_OUT(BUSY_OUT),
    .SAM_BUS_ADDR_OUT(SAM_BUS_ADDR_OUT), .TX_CRC_SEED_OUT(TX_CRC_SEED_OUT));
